/* design/hgc_pkg.sv */
/*
  Shared constants, carriers and state codes of the hybrid gain control sequencer.
  Assumes a 50 MHz system clock and a separate audio sample clock domain.
*/
package hgc_pkg;

  localparam int PAT_W   = 32;
  localparam int SIZE_W  = 6;
  localparam int GAIN_W  = 8;
  localparam int ACC_W   = 10;
  localparam int SAMP_W  = 24;
  localparam int CNT_W   = 16;
  localparam int NUM_SEG = 4;

  // Transmit order on the daisy chain: auxiliary 2, auxiliary 1, channel 2, channel 1.
  localparam logic [1:0] SEG_AUX2 = 2'h0;
  localparam logic [1:0] SEG_AUX1 = 2'h1;
  localparam logic [1:0] SEG_CH2  = 2'h2;
  localparam logic [1:0] SEG_CH1  = 2'h3;

  localparam logic [GAIN_W-1:0] GAIN_0DB_RST = 8'h00;
  localparam logic              CPOL_RST     = 1'b0;
  localparam logic [CNT_W-1:0]  CNT_RST      = 16'h0000;
  localparam logic [1:0]        PEND_RST     = 2'h0;

  typedef struct packed {
    logic [PAT_W-1:0]         chan_gain_pattern;
    logic [SIZE_W-1:0]        chan_pattern_size;
    logic signed [GAIN_W-1:0] chan_coarse_gain;
    logic signed [GAIN_W-1:0] chan_fine_gain;
  } hgc_chan_cfg_t;

  typedef struct packed {
    logic [PAT_W-1:0]  aux_device_pattern;
    logic [SIZE_W-1:0] aux_pattern_size;
  } hgc_aux_cfg_t;

  typedef struct packed {
    logic [7:0]       sck_div;
    logic             cpol;
    logic             cpha;
    logic [7:0]       cs_fall_delay;
    logic [7:0]       cs_rise_delay;
    logic [7:0]       cs_idle_delay;
    logic [CNT_W-1:0] zero_cross_wait_limit;
  } hgc_link_cfg_t;

  typedef struct packed {
    logic              masking_enable;
    logic              step_ramp_enable;
    logic [1:0]        chan_level_detect_enable;
    logic [3:0]        level_average_time_constant;
    logic [SAMP_W-1:0] level_mask_threshold;
    logic [CNT_W-1:0]  fine_gain_apply_delay;
    logic [CNT_W-1:0]  masking_onset_delay;
    logic [CNT_W-1:0]  masking_duration;
    logic [7:0]        ramp_up_rate;
    logic [7:0]        ramp_down_rate;
  } hgc_aud_cfg_t;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_SETUP = 5'b00010,
    ST_SHIFT = 5'b00100,
    ST_HOLD  = 5'b01000,
    ST_GAP   = 5'b10000
  } hgc_state_t;

  typedef enum logic [2:0] {
    MK_IDLE  = 3'b001,
    MK_ONSET = 3'b010,
    MK_HOLD  = 3'b100
  } hgc_mask_t;

endpackage

/* design/hgc_sequencer.sv */
/*
  Hybrid gain update sequencer: serial controller for daisy-chained gain devices,
  zero-cross timed chip-select release, delayed and ramped fine gain, transient masking.
  Assumes configuration ports are quasi-static and aud_cfg_i is driven in the aud_clk_i domain.
*/
// Functional notes
// - After shifting, hold chip select low until zero crossing or timeout, then release.
// - Delay each fine gain change after a coarse update to align in the stream.
// - Masking repeats one held sample throughout the masking interval.
// - Masking starts after an onset delay and lasts a programmed duration.
// - Per-channel level detector enable; level is an exponential moving average.
// - Detector on: mask only below threshold; detector off: always mask.
// - Patterns up to 32 bits, programmable size, sent MSB first from upper field.
// - Apply request marks channel pending; pending channels serviced one at a time.
// - Pending flag set while updates pending, self clears; settings accepted anytime.
// - Settings written without request are stored only, pending flag untouched.
// - Fine gain ramps at increase and decrease rates; it jumps only on an initialization load and on the compensation offset.
// - Coarse step first offset by opposite fine step, then ramped to target.
// - Step ramp enable selects compensation; cleared means no compensation.
// - Auxiliary patterns are held; newly written ones are sent only on an initialization request, applied ones in every other transaction.
// - Initialization sends all patterns, resets gains, no zero-cross wait or masking.
// - Initialization request ignored while pending flag is set.
// - Abort cancels pending channels; current channel finishes before going idle.
// - Each transaction lowers chip select and sends nonzero-size patterns in order.
// - Serial clock divides system clock; polarity, phase and select delays programmable.
`timescale 1ns/100ps
`default_nettype none

module hgc_sequencer (
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire logic                  aud_clk_i,
  input  var  hgc_pkg::hgc_chan_cfg_t chan_cfg_i [2],
  input  wire logic [1:0]            chan_cfg_write_i,
  input  wire logic [1:0]            chan_apply_request_i,
  input  var  hgc_pkg::hgc_aux_cfg_t aux_cfg_i [2],
  input  wire logic [1:0]            aux_cfg_write_i,
  input  wire logic                  init_update_i,
  input  wire logic                  abort_i,
  input  var  hgc_pkg::hgc_link_cfg_t link_cfg_i,
  input  var  hgc_pkg::hgc_aud_cfg_t aud_cfg_i,
  input  wire logic [hgc_pkg::SAMP_W-1:0] sample_i [2],
  input  wire logic                  sample_valid_i,
  output logic                       sck_o,
  output logic                       sdo_o,
  output logic                       cs_n_o,
  output logic                       gain_updates_pending_o,
  output logic [hgc_pkg::GAIN_W-1:0] chan_coarse_gain_o [2],
  output logic [hgc_pkg::ACC_W-1:0]  chan_fine_gain_o [2],
  output logic [hgc_pkg::SAMP_W-1:0] sample_o [2],
  output logic                       sample_valid_o
);

  function automatic logic [2:0] find_seg(input logic [3:0] nz, input logic [2:0] from);
    logic [2:0] res;
    res = 3'h0;
    for (int i = 3; i >= 0; i--) begin
      if (nz[i] && (3'(i) >= from)) begin
        res = {1'b1, 2'(i)};
      end
    end
    return res;
  endfunction

  // System domain state.
  hgc_pkg::hgc_state_t st_reg;
  hgc_pkg::hgc_chan_cfg_t shd_reg [2];
  hgc_pkg::hgc_aux_cfg_t  aux_shd_reg [2];
  hgc_pkg::hgc_aux_cfg_t  aux_app_reg [2];
  hgc_pkg::hgc_chan_cfg_t app_reg [2];
  logic [hgc_pkg::PAT_W-1:0]  tx_pat_reg [4];
  logic [hgc_pkg::SIZE_W-1:0] tx_size_reg [4];
  logic [hgc_pkg::CNT_W-1:0]  cnt_reg;
  logic [1:0]  pend_reg;
  logic [1:0]  seg_reg;
  logic [4:0]  bit_reg;
  logic        ph_reg;
  logic        act_ch_reg;
  logic        act_init_reg;
  logic        zc_seen_reg;
  logic        sck_reg;
  logic        sdo_reg;
  logic        cs_n_reg;
  logic        busy_reg;
  logic [1:0]  evt_tgl_reg;
  logic [1:0]  evt_init_reg;
  logic signed [hgc_pkg::GAIN_W-1:0] evt_delta_reg [2];
  logic signed [hgc_pkg::GAIN_W-1:0] evt_fine_reg [2];
  logic [2:0]  zc_sync_reg [2];
  logic [1:0]  zc_tgl_reg;

  wire logic [3:0] seg_nz = {tx_size_reg[3] != '0, tx_size_reg[2] != '0,
                             tx_size_reg[1] != '0, tx_size_reg[0] != '0};
  wire logic [2:0] first_seg = find_seg(seg_nz, 3'h0);
  wire logic [2:0] next_seg  = find_seg(seg_nz, 3'({1'b0, seg_reg}) + 3'h1);
  wire logic       last_bit  = ({1'b0, bit_reg} + 6'h01) >= tx_size_reg[seg_reg];
  wire logic       cur_bit   = tx_pat_reg[seg_reg][5'd31 - bit_reg];
  wire logic       nxt_bit   = tx_pat_reg[seg_reg][5'd30 - bit_reg];
  wire logic       half_tick = ({1'b0, cnt_reg[7:0]} + 9'h001) >= {1'b0, link_cfg_i.sck_div};
  wire logic [1:0] zc_evt    = {zc_sync_reg[1][2] ^ zc_sync_reg[1][1],
                                zc_sync_reg[0][2] ^ zc_sync_reg[0][1]};
  wire logic       init_go   = init_update_i && !busy_reg;
  wire logic       pick_ch   = !pend_reg[0];
  wire logic       svc_go    = (st_reg == hgc_pkg::ST_IDLE) && (pend_reg != 2'h0) && !init_go;
  wire logic       hold_done = (cnt_reg >= {8'h00, link_cfg_i.cs_rise_delay})
                               && (act_init_reg || zc_seen_reg
                                   || cnt_reg >= link_cfg_i.zero_cross_wait_limit);
  wire logic [1:0] svc_clr   = svc_go ? (pick_ch ? 2'h2 : 2'h1) : 2'h0;
  wire logic [1:0] pend_next = ((abort_i ? 2'h0 : pend_reg) & ~svc_clr)
                               | chan_apply_request_i;
  wire logic       idle_next = (st_reg == hgc_pkg::ST_IDLE) && !svc_go
                               && !(init_go && (st_reg == hgc_pkg::ST_IDLE));

  // Settings are stored whenever written, busy or not; they only reach the path on a request.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int c = 0; c < 2; c++) begin
        shd_reg[c]     <= '0;
        aux_shd_reg[c] <= '0;
      end
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (chan_cfg_write_i[c]) begin
          shd_reg[c] <= chan_cfg_i[c];
        end
        if (aux_cfg_write_i[c]) begin
          aux_shd_reg[c] <= aux_cfg_i[c];
        end
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pend_reg <= hgc_pkg::PEND_RST;
      busy_reg <= 1'b0;
      for (int c = 0; c < 2; c++) begin
        zc_sync_reg[c] <= 3'h0;
      end
    end else begin
      pend_reg <= pend_next;
      busy_reg <= (pend_next != 2'h0) || !idle_next;
      for (int c = 0; c < 2; c++) begin
        zc_sync_reg[c] <= {zc_sync_reg[c][1:0], zc_tgl_reg[c]};
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_reg       <= hgc_pkg::ST_IDLE;
      cnt_reg      <= hgc_pkg::CNT_RST;
      seg_reg      <= 2'h0;
      bit_reg      <= 5'h00;
      ph_reg       <= 1'b0;
      act_ch_reg   <= 1'b0;
      act_init_reg <= 1'b0;
      zc_seen_reg  <= 1'b0;
      sck_reg      <= hgc_pkg::CPOL_RST;
      sdo_reg      <= 1'b0;
      cs_n_reg     <= 1'b1;
      evt_tgl_reg  <= 2'h0;
      evt_init_reg <= 2'h0;
      for (int i = 0; i < hgc_pkg::NUM_SEG; i++) begin
        tx_pat_reg[i]  <= '0;
        tx_size_reg[i] <= '0;
      end
      for (int c = 0; c < 2; c++) begin
        app_reg[c]       <= '0;
        aux_app_reg[c]   <= '0;
        evt_delta_reg[c] <= hgc_pkg::GAIN_0DB_RST;
        evt_fine_reg[c]  <= hgc_pkg::GAIN_0DB_RST;
      end
    end else begin
      case (st_reg)
        hgc_pkg::ST_IDLE: begin
          sck_reg <= link_cfg_i.cpol;
          cnt_reg <= hgc_pkg::CNT_RST;
          if (init_go || svc_go) begin
            act_init_reg <= init_go;
            act_ch_reg   <= pick_ch;
            cs_n_reg     <= 1'b0;
            st_reg       <= hgc_pkg::ST_SETUP;
            // Written aux patterns leave the device only on initialization; otherwise the applied ones are resent.
            tx_pat_reg[hgc_pkg::SEG_AUX2]  <= init_go ? aux_shd_reg[1].aux_device_pattern
                                                      : aux_app_reg[1].aux_device_pattern;
            tx_size_reg[hgc_pkg::SEG_AUX2] <= init_go ? aux_shd_reg[1].aux_pattern_size
                                                      : aux_app_reg[1].aux_pattern_size;
            tx_pat_reg[hgc_pkg::SEG_AUX1]  <= init_go ? aux_shd_reg[0].aux_device_pattern
                                                      : aux_app_reg[0].aux_device_pattern;
            tx_size_reg[hgc_pkg::SEG_AUX1] <= init_go ? aux_shd_reg[0].aux_pattern_size
                                                      : aux_app_reg[0].aux_pattern_size;
            // The whole chain is rewritten, so idle channels resend their applied pattern.
            for (int c = 0; c < 2; c++) begin
              if (init_go || (pick_ch == c[0])) begin
                tx_pat_reg[3-c]  <= shd_reg[c].chan_gain_pattern;
                tx_size_reg[3-c] <= shd_reg[c].chan_pattern_size;
              end else begin
                tx_pat_reg[3-c]  <= app_reg[c].chan_gain_pattern;
                tx_size_reg[3-c] <= app_reg[c].chan_pattern_size;
              end
            end
          end
        end
        hgc_pkg::ST_SETUP: begin
          cnt_reg <= cnt_reg + 16'h0001;
          if (cnt_reg >= {8'h00, link_cfg_i.cs_fall_delay}) begin
            cnt_reg <= hgc_pkg::CNT_RST;
            seg_reg <= first_seg[1:0];
            bit_reg <= 5'h00;
            ph_reg  <= 1'b0;
            sdo_reg <= tx_pat_reg[first_seg[1:0]][31];
            st_reg  <= first_seg[2] ? hgc_pkg::ST_SHIFT : hgc_pkg::ST_HOLD;
            zc_seen_reg <= 1'b0;
          end
        end
        hgc_pkg::ST_SHIFT: begin
          cnt_reg <= half_tick ? hgc_pkg::CNT_RST : cnt_reg + 16'h0001;
          if (half_tick) begin
            ph_reg <= !ph_reg;
            if (!ph_reg) begin
              sck_reg <= !link_cfg_i.cpol;
              if (link_cfg_i.cpha) begin
                sdo_reg <= cur_bit;
              end
            end else begin
              sck_reg <= link_cfg_i.cpol;
              if (!last_bit) begin
                bit_reg <= bit_reg + 5'h01;
                if (!link_cfg_i.cpha) begin
                  sdo_reg <= nxt_bit;
                end
              end else if (next_seg[2]) begin
                seg_reg <= next_seg[1:0];
                bit_reg <= 5'h00;
                if (!link_cfg_i.cpha) begin
                  sdo_reg <= tx_pat_reg[next_seg[1:0]][31];
                end
              end else begin
                st_reg      <= hgc_pkg::ST_HOLD;
                zc_seen_reg <= 1'b0;
              end
            end
          end
        end
        hgc_pkg::ST_HOLD: begin
          cnt_reg <= cnt_reg + 16'h0001;
          if (zc_evt[act_ch_reg]) begin
            zc_seen_reg <= 1'b1;
          end
          if (hold_done) begin
            cs_n_reg <= 1'b1;
            cnt_reg  <= hgc_pkg::CNT_RST;
            st_reg   <= hgc_pkg::ST_GAP;
            if (act_init_reg) begin
              aux_app_reg[0] <= aux_shd_reg[0];
              aux_app_reg[1] <= aux_shd_reg[1];
            end
            for (int c = 0; c < 2; c++) begin
              if (act_init_reg || (act_ch_reg == c[0])) begin
                app_reg[c]       <= shd_reg[c];
                evt_delta_reg[c] <= shd_reg[c].chan_coarse_gain - app_reg[c].chan_coarse_gain;
                evt_fine_reg[c]  <= shd_reg[c].chan_fine_gain;
                evt_init_reg[c]  <= act_init_reg;
                evt_tgl_reg[c]   <= !evt_tgl_reg[c];
              end
            end
          end
        end
        hgc_pkg::ST_GAP: begin
          cnt_reg <= cnt_reg + 16'h0001;
          if (cnt_reg >= {8'h00, link_cfg_i.cs_idle_delay}) begin
            st_reg <= hgc_pkg::ST_IDLE;
          end
        end
        default: begin
          st_reg   <= hgc_pkg::ST_IDLE;
          cs_n_reg <= 1'b1;
        end
      endcase
    end
  end

  assign sck_o                  = sck_reg;
  assign sdo_o                  = sdo_reg;
  assign cs_n_o                 = cs_n_reg;
  assign gain_updates_pending_o = busy_reg;
  for (genvar c = 0; c < 2; c++) begin : g_coarse
    assign chan_coarse_gain_o[c] = app_reg[c].chan_coarse_gain;
  end

  // Audio domain reset is released synchronously so no channel leaves reset a cycle early.
  logic [1:0] aud_rst_reg;
  always_ff @(posedge aud_clk_i or posedge rst_i) begin
    if (rst_i) begin
      aud_rst_reg <= 2'h3;
    end else begin
      aud_rst_reg <= {aud_rst_reg[0], 1'b0};
    end
  end
  wire logic aud_rst = aud_rst_reg[1];

  always_ff @(posedge aud_clk_i or posedge aud_rst) begin
    if (aud_rst) begin
      sample_valid_o <= 1'b0;
    end else begin
      sample_valid_o <= sample_valid_i;
    end
  end

  for (genvar c = 0; c < 2; c++) begin : g_chan
    logic [2:0]             ev_sync_reg;
    logic [hgc_pkg::CNT_W-1:0] dly_cnt_reg;
    logic [hgc_pkg::CNT_W-1:0] mk_cnt_reg;
    logic                   dly_act_reg;
    hgc_pkg::hgc_mask_t     mk_reg;
    logic signed [hgc_pkg::ACC_W-1:0]  cur_reg;
    logic signed [hgc_pkg::ACC_W-1:0]  tgt_reg;
    logic signed [hgc_pkg::GAIN_W-1:0] pdelta_reg;
    logic signed [hgc_pkg::GAIN_W-1:0] pfine_reg;
    logic [7:0]             ramp_reg;
    logic [hgc_pkg::SAMP_W-1:0] lvl_reg;
    logic [hgc_pkg::SAMP_W-1:0] held_reg;
    logic [hgc_pkg::SAMP_W-1:0] out_reg;
    logic                   sign_reg;

    // Event data stays stable in the system domain for a whole transaction after the toggle.
    wire logic ev = ev_sync_reg[2] ^ ev_sync_reg[1];
    wire logic signed [hgc_pkg::SAMP_W-1:0] smp = sample_i[c];
    wire logic [hgc_pkg::SAMP_W-1:0] mag = smp[hgc_pkg::SAMP_W-1] ? 24'(-smp) : 24'(smp);
    wire logic signed [hgc_pkg::SAMP_W:0] diff = {1'b0, mag} - {1'b0, lvl_reg};
    wire logic signed [hgc_pkg::SAMP_W:0] step = diff >>> aud_cfg_i.level_average_time_constant;
    wire logic quiet = !aud_cfg_i.chan_level_detect_enable[c]
                       || (lvl_reg < aud_cfg_i.level_mask_threshold);
    wire logic going_up = cur_reg < tgt_reg;
    wire logic [7:0] rate = going_up ? aud_cfg_i.ramp_up_rate : aud_cfg_i.ramp_down_rate;
    wire logic ramp_step = (rate != 8'h00) && ((ramp_reg + 8'h01) >= rate);

    always_ff @(posedge aud_clk_i or posedge aud_rst) begin
      if (aud_rst) begin
        ev_sync_reg <= 3'h0;
        dly_cnt_reg <= hgc_pkg::CNT_RST;
        mk_cnt_reg  <= hgc_pkg::CNT_RST;
        dly_act_reg <= 1'b0;
        mk_reg      <= hgc_pkg::MK_IDLE;
        cur_reg     <= '0;
        tgt_reg     <= '0;
        pdelta_reg  <= hgc_pkg::GAIN_0DB_RST;
        pfine_reg   <= hgc_pkg::GAIN_0DB_RST;
        ramp_reg    <= 8'h00;
        lvl_reg     <= '0;
        held_reg    <= '0;
        out_reg     <= '0;
        sign_reg    <= 1'b0;
        zc_tgl_reg[c] <= 1'b0;
      end else begin
        ev_sync_reg <= {ev_sync_reg[1:0], evt_tgl_reg[c]};
        if (ev && evt_init_reg[c]) begin
          cur_reg     <= ACC_EXT(evt_fine_reg[c]);
          tgt_reg     <= ACC_EXT(evt_fine_reg[c]);
          dly_act_reg <= 1'b0;
          mk_reg      <= hgc_pkg::MK_IDLE;
        end else if (ev) begin
          dly_act_reg <= 1'b1;
          dly_cnt_reg <= hgc_pkg::CNT_RST;
          pdelta_reg  <= aud_cfg_i.step_ramp_enable ? evt_delta_reg[c] : '0;
          pfine_reg   <= evt_fine_reg[c];
          mk_cnt_reg  <= hgc_pkg::CNT_RST;
          mk_reg      <= (aud_cfg_i.masking_enable && quiet) ? hgc_pkg::MK_ONSET
                                                             : hgc_pkg::MK_IDLE;
        end else if (sample_valid_i) begin
          if (dly_act_reg) begin
            dly_cnt_reg <= dly_cnt_reg + 16'h0001;
            if (dly_cnt_reg >= aud_cfg_i.fine_gain_apply_delay) begin
              dly_act_reg <= 1'b0;
              cur_reg     <= cur_reg - ACC_EXT(pdelta_reg);
              tgt_reg     <= ACC_EXT(pfine_reg);
              ramp_reg    <= 8'h00;
            end
          end else if (cur_reg != tgt_reg) begin
            ramp_reg <= ramp_step ? 8'h00 : ramp_reg + 8'h01;
            if (ramp_step) begin
              cur_reg <= going_up ? cur_reg + 10'sd1 : cur_reg - 10'sd1;
            end
          end
          mk_cnt_reg <= mk_cnt_reg + 16'h0001;
          case (mk_reg)
            hgc_pkg::MK_IDLE: begin
              mk_cnt_reg <= hgc_pkg::CNT_RST;
            end
            hgc_pkg::MK_ONSET: begin
              if (mk_cnt_reg >= aud_cfg_i.masking_onset_delay) begin
                mk_reg     <= hgc_pkg::MK_HOLD;
                mk_cnt_reg <= hgc_pkg::CNT_RST;
                held_reg   <= out_reg;
              end
            end
            hgc_pkg::MK_HOLD: begin
              if ((mk_cnt_reg + 16'h0001) >= aud_cfg_i.masking_duration) begin
                mk_reg <= hgc_pkg::MK_IDLE;
              end
            end
            default: begin
              mk_reg <= hgc_pkg::MK_IDLE;
            end
          endcase
        end
        // Sample-side state sees every sample, so an event never drops one from the stream.
        if (sample_valid_i) begin
          sign_reg <= smp[hgc_pkg::SAMP_W-1];
          if (sign_reg != smp[hgc_pkg::SAMP_W-1]) begin
            zc_tgl_reg[c] <= !zc_tgl_reg[c];
          end
          lvl_reg <= 24'(({1'b0, lvl_reg}) + step);
          out_reg <= (mk_reg == hgc_pkg::MK_HOLD) ? held_reg : sample_i[c];
        end
      end
    end

    assign sample_o[c]         = out_reg;
    assign chan_fine_gain_o[c] = cur_reg;
  end

  function automatic logic signed [hgc_pkg::ACC_W-1:0] ACC_EXT(
    input logic signed [hgc_pkg::GAIN_W-1:0] g);
    return {{(hgc_pkg::ACC_W-hgc_pkg::GAIN_W){g[hgc_pkg::GAIN_W-1]}}, g};
  endfunction

endmodule // hgc_sequencer

`default_nettype wire

/* bench/hgc_sequencer_sva.sv */
/* Port checker for the gain update sequencer, clk_i domain only.
   Assumes mode 0 serial clocking and an idle gap setting of 1. */
`timescale 1ns/100ps
`default_nettype none
module hgc_sequencer_sva (
  input wire logic                       clk_i,
  input wire logic                       rst_i,
  input wire logic [1:0]                 chan_apply_request_i,
  input wire logic                       init_update_i,
  input wire logic                       abort_i,
  input var  hgc_pkg::hgc_link_cfg_t     link_cfg_i,
  input wire logic                       sck_o,
  input wire logic                       sdo_o,
  input wire logic                       cs_n_o,
  input wire logic                       gain_updates_pending_o,
  input wire logic [hgc_pkg::GAIN_W-1:0] chan_coarse_gain_o [2]
);
  localparam int CS_MAX = 400;
  logic [15:0] low_cnt;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // A counter, because a timeout wait is far longer than a repetition may be.
  always_ff @(posedge clk_i or posedge rst_i) begin
    low_cnt <= (rst_i || cs_n_o) ? 16'h0000 : low_cnt + 16'h0001;
  end
  sequence s_gap;
    cs_n_o [*2];
  endsequence
  AST_PEND_SET: assert property (
    |chan_apply_request_i |=> gain_updates_pending_o) else $error("pending not set");
  AST_PEND_HOLD: assert property (
    !cs_n_o && !$past(cs_n_o) |-> gain_updates_pending_o) else $error("busy dropped");
  AST_INIT_GO: assert property (
    init_update_i && !gain_updates_pending_o |=> !cs_n_o) else $error("init not started");
  AST_CS_START: assert property (
    $fell(cs_n_o) |-> $past(init_update_i) || $past(gain_updates_pending_o))
    else $error("stray transaction");
  AST_SCK_IDLE: assert property (
    cs_n_o |-> sck_o == link_cfg_i.cpol) else $error("clock not idle");
  AST_SDO_STABLE: assert property (
    $rose(sck_o) |-> $stable(sdo_o)) else $error("data moved on sample edge");
  AST_GAP: assert property (
    $rose(cs_n_o) |-> s_gap) else $error("idle gap short");
  AST_COARSE: assert property (
    $changed(chan_coarse_gain_o[0]) || $changed(chan_coarse_gain_o[1]) |-> $rose(cs_n_o))
    else $error("gain changed off release");
  AST_TIMEOUT: assert property (
    low_cnt < CS_MAX) else $error("select held too long");
  AST_ABORT: assert property (
    abort_i && !chan_apply_request_i |-> ##[1:600] !gain_updates_pending_o)
    else $error("abort did not idle");
endmodule // hgc_sequencer_sva
bind hgc_sequencer hgc_sequencer_sva i_sva (.clk_i(clk_i), .rst_i(rst_i),
  .chan_apply_request_i(chan_apply_request_i), .init_update_i(init_update_i),
  .abort_i(abort_i), .link_cfg_i(link_cfg_i), .sck_o(sck_o), .sdo_o(sdo_o),
  .cs_n_o(cs_n_o), .gain_updates_pending_o(gain_updates_pending_o),
  .chan_coarse_gain_o(chan_coarse_gain_o));
`default_nettype wire

/* bench/hgc_gain_chain.sv */
/* Model of the daisy-chained gain devices on the serial link.
   Assumes mode 0: data is taken on the rising serial clock edge. */
`timescale 1ns/100ps
`default_nettype none
module hgc_gain_chain (
  input  wire logic   sck_i,
  input  wire logic   sdo_i,
  input  wire logic   cs_n_i,
  output logic [127:0] frame_o,
  output logic [7:0]   nbits_o
);
  logic [127:0] sh;
  logic [7:0]   n;
  always @(negedge cs_n_i) begin
    sh <= 128'h0;
    n <= 8'h00;
  end
  always @(posedge sck_i) begin
    if (!cs_n_i) begin
      sh <= {sh[126:0], sdo_i};
      n <= n + 8'h01;
    end
  end
  // The chain applies its word only when select rises.
  always @(posedge cs_n_i) begin
    frame_o <= sh;
    nbits_o <= n;
  end
endmodule // hgc_gain_chain
`default_nettype wire

/* bench/hgc_sequencer_tb.sv */
/* Self-checking bench for the gain update sequencer with a device chain model.
   Assumes mode 0 serial clocking and quasi-static configuration. */
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_mismatch++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module hgc_sequencer_tb;
  logic clk_i, rst_i, aud_clk_i, init_update_i, abort_i, sv, zc, sck, sdo, cs_n, pend, neg;
  logic [1:0]             cw, req, aw;
  hgc_pkg::hgc_chan_cfg_t cc [2];
  hgc_pkg::hgc_aux_cfg_t  ac [2];
  hgc_pkg::hgc_link_cfg_t lc;
  hgc_pkg::hgc_aud_cfg_t  au;
  logic [23:0]            si [2];
  logic [23:0]            so [2];
  logic [23:0]            prv;
  logic                   svo;
  logic [7:0]             cg [2];
  logic [9:0]             fg [2];
  logic [127:0]           frame;
  logic [7:0]             nb;
  int                     n_mismatch, compares, n_tx, rep;
  hgc_sequencer i_dut (.clk_i(clk_i), .rst_i(rst_i), .aud_clk_i(aud_clk_i), .chan_cfg_i(cc),
    .chan_cfg_write_i(cw), .chan_apply_request_i(req), .aux_cfg_i(ac), .aux_cfg_write_i(aw),
    .init_update_i(init_update_i), .abort_i(abort_i), .link_cfg_i(lc), .aud_cfg_i(au),
    .sample_i(si), .sample_valid_i(sv), .sck_o(sck), .sdo_o(sdo), .cs_n_o(cs_n),
    .gain_updates_pending_o(pend), .chan_coarse_gain_o(cg), .chan_fine_gain_o(fg),
    .sample_o(so), .sample_valid_o(svo));
  hgc_gain_chain i_chain (.sck_i(sck), .sdo_i(sdo), .cs_n_i(cs_n), .frame_o(frame), .nbits_o(nb));
  initial begin clk_i = 0; forever #10 clk_i = ~clk_i; end
  initial begin aud_clk_i = 0; #1.7; forever #3 aud_clk_i = ~aud_clk_i; end
  always @(negedge cs_n) n_tx++;
  // Outputs are looked at on the falling audio edge, where they have settled.
  always @(negedge aud_clk_i) begin
    if (fg[0][9] === 1'b1) neg = 1'b1;
    if (so[0] === prv) rep++;
    prv = so[0];
  end
  // Alternating sign gives a zero crossing every sample; a constant never crosses.
  always @(negedge aud_clk_i) begin
    sv <= 1'b1;
    for (int c = 0; c < 2; c++) si[c] <= (zc && !si[c][23]) ? 24'hFFFC18 : 24'h0003E8;
  end
  task automatic chan(input int c, input logic [31:0] p, input logic [5:0] s,
                      input logic [7:0] g, input logic [7:0] f, input logic r);
    cc[c] = '{p, s, g, f};
    cw[c] = 1'b1;
    req[c] = r;
    @(negedge clk_i);
    {cw, req} = 4'h0;
  endtask
  task automatic pulse(input int k);
    if (k == 0) aw = 2'h3; else if (k == 1) init_update_i = 1'b1; else abort_i = 1'b1;
    @(negedge clk_i);
    {aw, init_update_i, abort_i} = 4'h0;
  endtask
  task automatic settle();
    @(negedge clk_i);
    for (int i = 0; i < 3000 && pend !== 1'b0; i++) @(negedge clk_i);
    if (pend !== 1'b0) n_mismatch++;
  endtask
  task automatic results();
    if (n_mismatch == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin #400000; n_mismatch++; results(); end
  initial begin
    {cw, req, aw, init_update_i, abort_i, sv, zc, neg} = '0;
    {n_mismatch, compares, n_tx} = '0;
    si = '{24'h0, 24'h0};
    cc = '{default: '0};
    ac = '{'{32'hFFFFFFFF, 6'h00}, '{32'hC3000000, 6'h08}};
    lc = '{8'h01, 1'b0, 1'b0, 8'h02, 8'h01, 8'h01, 16'h0028};
    au = '{1'b0, 1'b1, 2'h0, 4'h4, 24'h000100, 16'h0004,
           16'h0002, 16'h0004, 8'h01, 8'h01};
    rst_i = 1'b1;
    repeat (5) @(negedge clk_i);
    rst_i = 1'b0;
    chan(0, 32'hA5C30000, 6'h10, 8'h00, 8'h04, 1'b0);
    chan(1, 32'h5A5A5000, 6'h14, 8'h06, 8'h00, 1'b0);
    repeat (4) @(negedge clk_i);
    `CHK({pend, cg[1]}, 9'h000)
    pulse(0);
    pulse(1);
    settle();
    `CHK(nb, 8'h2C)
    `CHK(frame[43:0], {8'hC3, 20'h5A5A5, 16'hA5C3})
    `CHK(cg[1], 8'h06)
    ac[1] = '{32'h3C000000, 6'h08};
    pulse(0);
    neg = 1'b0;
    chan(0, 32'h12340000, 6'h10, 8'h08, 8'h06, 1'b1);
    settle();
    `CHK(frame[43:0], {8'hC3, 20'h5A5A5, 16'h1234})
    `CHK(cg[0], 8'h08)
    repeat (60) @(negedge clk_i);
    `CHK({neg, fg[0]}, 11'h006 | 11'h400)
    zc = 1'b1;
    chan(0, 32'h56780000, 6'h10, 8'h04, 8'h06, 1'b1);
    chan(1, 32'h77700000, 6'h14, 8'h0C, 8'h00, 1'b1);
    pulse(2);
    pulse(1);
    settle();
    `CHK({cg[0], cg[1]}, 16'h0406)
    `CHK(n_tx, 3)
    au.masking_enable = 1'b1;
    au.chan_level_detect_enable = 2'h1;
    rep = 0;
    chan(0, 32'h56780000, 6'h10, 8'h04, 8'h06, 1'b1);
    settle();
    repeat (10) @(negedge clk_i);
    `CHK(rep, 0)
    au.chan_level_detect_enable = 2'h0;
    chan(0, 32'h56780000, 6'h10, 8'h04, 8'h06, 1'b1);
    settle();
    repeat (10) @(negedge clk_i);
    `CHK(rep > 2 && rep < 6, 1'b1)
    `CHK(svo, 1'b1)
    results();
  end
endmodule // hgc_sequencer_tb
`default_nettype wire
